/* File: rtl/phy_cfg_pkg.sv */
// Purpose: constants for the port phy mode and crossover control block
// Assumes: 5-bit phy register index space, one port per instance
// Notes: register indices are decimal register numbers
`default_nettype none
package phy_cfg_pkg;
    localparam logic [4:0] IDX_SPECIAL_MODES    = 5'h12;
    localparam logic [4:0] IDX_SPECIAL_CTRL_IND = 5'h1b;
    localparam int MODE_LSB      = 5;
    localparam int MODE_MSB      = 7;
    localparam int XO_SRC_BIT    = 15;
    localparam int XO_AUTO_BIT   = 14;
    localparam int XO_STATE_BIT  = 13;
    localparam int HB_DIS_BIT    = 11;
    localparam int PLL_LOCK_BIT  = 10;
    localparam int POL_BIT       = 4;
    localparam logic [2:0] MODE_ALL_CAPABLE = 3'h7;
    localparam logic [15:0] RD_ZERO = 16'h0000;

    typedef enum logic [2:0] {
        MODE_10_HD    = 3'b000,
        MODE_10_FD    = 3'b001,
        MODE_100_HD   = 3'b010,
        MODE_100_FD   = 3'b011,
        MODE_AN_100HD = 3'b100,
        MODE_REPEATER = 3'b101,
        MODE_PWR_DOWN = 3'b110,
        MODE_AN_ALL   = 3'b111
    } phy_mode_type;

    // crossover result: straight, crossed, automatic
    typedef enum logic [1:0] {
        XO_STRAIGHT = 2'b00,
        XO_CROSSED  = 2'b01,
        XO_AUTO     = 2'b10
    } xo_mode_type;

    // basic control bits 13,12,10,8 and advertisement bits 8..5
    localparam logic [3:0] BC_10_HD   = 4'h0;
    localparam logic [3:0] BC_10_FD   = 4'h1;
    localparam logic [3:0] BC_100_HD  = 4'h8;
    localparam logic [3:0] BC_100_FD  = 4'h9;
    localparam logic [3:0] BC_AN_100  = 4'hc;
    localparam logic [3:0] BC_ALL_SET = 4'h4;
    localparam logic [3:0] BC_ALL_USE = 4'h6;
    localparam logic [3:0] ADV_100_HD = 4'h4;
    localparam logic [3:0] ADV_ALL    = 4'hf;
endpackage
`default_nettype wire

/* File: rtl/phy_mode_and_mdix_control.sv */
// Purpose: per-port phy mode decode and special control/indication register
// Assumes: straps and polarity arrive from pins; software on a plain port
// Notes: the two resets below act on this block only
// Notes on behaviour
// [RL1] mode 011 forces 100 full duplex, no autoneg, crs on receive, 1001.
// [RL2] mode 100 autonegotiates advertising 100 half only, control 1100/0100.
// [RL3] mode 101 is repeater mode with the same bits as 100, crs on receive.
// [RL4] mode 110 is power down and the decode sets no control bits.
// [RL5] mode 111 advertises all, sets bits 12/10 to 1/0 and advert 1111.
// [RL6] with the source bit clear, crossover follows the latched straps.
// [RL7] with the source bit set, crossover follows bits 14 and 13.
// [RL8] under register control 00 straight, 01 crossed, 10 automatic.
// [RL9] software never writes bits 14 and 13 both as 1.
// [RL10] heartbeat test runs unless bit 11 is set.
// [RL11] bit 10 set holds the 10M receive pll on reference, blocking 10M rx.
// [RL12] bit 4 reads the detected 10BASE-T polarity, 1 meaning reversed.
// [RL13] control bits clear on chip-level phy reset, survive soft reset.
// [RL14] the mode field is bits 7..5 of the special modes register, r/w.
// [RL15] after chip reset mode is 111 on autoneg strap, else 0,speed,duplex; code loads it after i_srst only.
// [RL16] reserved bits read as zero and ignore writes.
//
// Added by the designer: the plain strobed port.
`default_nettype none
module phy_mode_and_mdix_control
    import phy_cfg_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_srst,
    input  wire logic        i_phy_chip_rst,
    input  wire logic        i_phy_soft_rst,
    input  wire logic [4:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic        i_autoneg_strap,
    input  wire logic        i_speed_strap,
    input  wire logic        i_duplex_strap,
    input  wire logic        i_manual_xo_strap,
    input  wire logic        i_auto_xo_strap,
    input  wire logic        i_rx_polarity_reversed,
    output logic [15:0]      o_rdata,
    output logic [3:0]       o_basic_ctrl_bits,
    output logic [3:0]       o_basic_ctrl_mask,
    output logic [3:0]       o_adv_bits,
    output logic             o_adv_valid,
    output logic             o_power_down,
    output logic             o_crs_on_tx,
    output logic             o_repeater_mode,
    output logic [1:0]       o_crossover_mode,
    output logic             o_heartbeat_test_en,
    output logic             o_rx_pll_force_reference_lock
);
    // pin inputs pass three stages; polarity counts once two and three agree
    logic [2:0] pol_sync_r;
    logic [2:0] pol_sync_nxt;
    logic [2:0] man_sync_r;
    logic [2:0] man_sync_nxt;
    logic [2:0] aut_sync_r;
    logic [2:0] aut_sync_nxt;
    logic [2:0] an_sync_r;
    logic [2:0] an_sync_nxt;
    logic [2:0] spd_sync_r;
    logic [2:0] spd_sync_nxt;
    logic [2:0] dup_sync_r;
    logic [2:0] dup_sync_nxt;
    logic       pol_r;
    logic       pol_nxt;
    logic       man_strap_r;
    logic       man_strap_nxt;
    logic       aut_strap_r;
    logic       aut_strap_nxt;
    logic       strap_take_r;
    logic       strap_take_nxt;

    // register state
    logic [2:0] mode_r;
    logic [2:0] mode_nxt;
    logic       xo_src_r;
    logic       xo_src_nxt;
    logic       xo_auto_r;
    logic       xo_auto_nxt;
    logic       xo_state_r;
    logic       xo_state_nxt;
    logic       hb_dis_r;
    logic       hb_dis_nxt;
    logic       pll_lock_r;
    logic       pll_lock_nxt;
    logic [15:0] rdata_nxt;

    // decoded outputs
    logic [3:0] bc_nxt;
    logic [3:0] bcm_nxt;
    logic [3:0] adv_nxt;
    logic       advv_nxt;
    logic       pd_nxt;
    logic       crs_tx_nxt;
    logic       rep_nxt;
    logic [1:0] xo_nxt;
    logic       hb_en_nxt;
    logic       pll_out_nxt;

    // i_phy_soft_rst is left unread: a soft reset keeps every bit here
    logic wr_modes;
    logic wr_ctrl;

    assign wr_modes = i_wr && (i_addr == IDX_SPECIAL_MODES);
    assign wr_ctrl  = i_wr && (i_addr == IDX_SPECIAL_CTRL_IND);

    // the mode field must be exactly as wide as the mode code
    if (MODE_MSB - MODE_LSB + 1 != $bits(phy_mode_type)) begin : g_mode_width
        $error("mode field width does not match the mode code");
    end
    // every control field must sit inside the register word
    if (XO_SRC_BIT >= $bits(RD_ZERO) || MODE_MSB >= $bits(RD_ZERO)) begin : g_pos
        $error("register field lies outside the register word");
    end

    always_comb begin
        pol_sync_nxt = {pol_sync_r[1:0], i_rx_polarity_reversed};
        man_sync_nxt = {man_sync_r[1:0], i_manual_xo_strap};
        aut_sync_nxt = {aut_sync_r[1:0], i_auto_xo_strap};
        an_sync_nxt  = {an_sync_r[1:0], i_autoneg_strap};
        spd_sync_nxt = {spd_sync_r[1:0], i_speed_strap};
        dup_sync_nxt = {dup_sync_r[1:0], i_duplex_strap};
        pol_nxt = (pol_sync_r[2] == pol_sync_r[1]) ? pol_sync_r[2] : pol_r;
        // crossover straps latched once, at the first edge after i_srst release
        strap_take_nxt = 1'b0;
        man_strap_nxt  = man_strap_r;
        aut_strap_nxt  = aut_strap_r;
        // straps sit still through reset, so stage three has settled
        if (strap_take_r) begin
            man_strap_nxt = man_sync_r[2];
            aut_strap_nxt = aut_sync_r[2];
        end
    end

    always_comb begin
        mode_nxt     = mode_r;
        xo_src_nxt   = xo_src_r;
        xo_auto_nxt  = xo_auto_r;
        xo_state_nxt = xo_state_r;
        hb_dis_nxt   = hb_dis_r;
        pll_lock_nxt = pll_lock_r;
        if (strap_take_r) begin
            // default taken from straps after reset release
            mode_nxt = an_sync_r[2] ? MODE_ALL_CAPABLE
                     : {1'b0, spd_sync_r[2], dup_sync_r[2]}; // [RL15]
        end else if (wr_modes) begin
            mode_nxt = i_wdata[MODE_MSB:MODE_LSB]; // [RL14]
        end
        if (wr_ctrl) begin
            // only defined bits stored; others dropped [RL16]
            xo_src_nxt   = i_wdata[XO_SRC_BIT];
            xo_auto_nxt  = i_wdata[XO_AUTO_BIT];
            xo_state_nxt = i_wdata[XO_STATE_BIT];
            hb_dis_nxt   = i_wdata[HB_DIS_BIT];
            pll_lock_nxt = i_wdata[PLL_LOCK_BIT];
        end
        // soft reset leaves these alone; chip-level phy reset clears, as does i_srst
        if (i_phy_chip_rst) begin // [RL13]
            xo_src_nxt   = 1'b0;
            xo_auto_nxt  = 1'b0;
            xo_state_nxt = 1'b0;
            hb_dis_nxt   = 1'b0;
            pll_lock_nxt = 1'b0;
        end
    end

    always_comb begin
        rdata_nxt = RD_ZERO; // [RL16]
        if (i_rd) begin
            if (i_addr == IDX_SPECIAL_MODES) begin
                rdata_nxt[MODE_MSB:MODE_LSB] = mode_r;
            end else if (i_addr == IDX_SPECIAL_CTRL_IND) begin
                rdata_nxt[XO_SRC_BIT]   = xo_src_r;
                rdata_nxt[XO_AUTO_BIT]  = xo_auto_r;
                rdata_nxt[XO_STATE_BIT] = xo_state_r;
                rdata_nxt[HB_DIS_BIT]   = hb_dis_r;
                rdata_nxt[PLL_LOCK_BIT] = pll_lock_r;
                rdata_nxt[POL_BIT]      = pol_r; // [RL12]
            end
        end
    end

    always_comb begin
        bc_nxt     = BC_10_HD;
        bcm_nxt    = 4'hf;
        adv_nxt    = ADV_ALL;
        advv_nxt   = 1'b0;
        pd_nxt     = 1'b0;
        crs_tx_nxt = 1'b0;
        rep_nxt    = 1'b0;
        unique case (phy_mode_type'(mode_r))
            MODE_10_HD: begin
                bc_nxt     = BC_10_HD;
                crs_tx_nxt = 1'b1;
            end
            MODE_10_FD: bc_nxt = BC_10_FD;
            MODE_100_HD: begin
                bc_nxt     = BC_100_HD;
                crs_tx_nxt = 1'b1;
            end
            MODE_100_FD: bc_nxt = BC_100_FD; // [RL1]
            MODE_AN_100HD: begin
                bc_nxt     = BC_AN_100; // [RL2]
                adv_nxt    = ADV_100_HD;
                advv_nxt   = 1'b1;
                crs_tx_nxt = 1'b1;
            end
            MODE_REPEATER: begin
                bc_nxt   = BC_AN_100; // [RL3]
                adv_nxt  = ADV_100_HD;
                advv_nxt = 1'b1;
                rep_nxt  = 1'b1;
            end
            MODE_PWR_DOWN: begin
                bcm_nxt = 4'h0; // [RL4]
                pd_nxt  = 1'b1;
            end
            MODE_AN_ALL: begin
                // bits 13 and 8 untouched: mask covers 12 and 10 only
                bc_nxt     = BC_ALL_SET; // [RL5]
                bcm_nxt    = BC_ALL_USE;
                adv_nxt    = ADV_ALL;
                advv_nxt   = 1'b1;
                crs_tx_nxt = 1'b1;
            end
        endcase
    end

    // crossover source and heartbeat/pll outputs
    always_comb begin
        hb_en_nxt   = ~hb_dis_r; // [RL10]
        pll_out_nxt = pll_lock_r; // [RL11]
        // 11 is reserved; software keeps clear of it, read as automatic [RL9]
        if (xo_src_r) begin // [RL7]
            if (xo_auto_r) begin
                xo_nxt = XO_AUTO; // [RL8]
            end else begin
                xo_nxt = xo_state_r ? XO_CROSSED : XO_STRAIGHT; // [RL8]
            end
        end else if (aut_strap_r) begin // [RL6]
            xo_nxt = XO_AUTO;
        end else begin
            xo_nxt = man_strap_r ? XO_CROSSED : XO_STRAIGHT; // [RL6]
        end
    end

    // no reset here: straps must reach stage three before reset release
    // limitation: a reset shorter than three cycles latches stale straps
    always_ff @(posedge i_clk_sys) begin
        pol_sync_r <= pol_sync_nxt;
        man_sync_r <= man_sync_nxt;
        aut_sync_r <= aut_sync_nxt;
        an_sync_r  <= an_sync_nxt;
        spd_sync_r <= spd_sync_nxt;
        dup_sync_r <= dup_sync_nxt;
    end

    // every output registered; decode lands two edges after a write
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            pol_r        <= 1'b0;
            man_strap_r  <= 1'b0;
            aut_strap_r  <= 1'b0;
            strap_take_r <= 1'b1;
            mode_r       <= MODE_ALL_CAPABLE;
            xo_src_r     <= 1'b0;
            xo_auto_r    <= 1'b0;
            xo_state_r   <= 1'b0;
            hb_dis_r     <= 1'b0;
            pll_lock_r   <= 1'b0;
            o_rdata      <= RD_ZERO;
            o_basic_ctrl_bits <= 4'h0;
            o_basic_ctrl_mask <= 4'h0;
            o_adv_bits   <= 4'h0;
            o_adv_valid  <= 1'b0;
            o_power_down <= 1'b0;
            o_crs_on_tx  <= 1'b0;
            o_repeater_mode <= 1'b0;
            o_crossover_mode <= 2'h0;
            o_heartbeat_test_en <= 1'b1;
            o_rx_pll_force_reference_lock <= 1'b0;
        end else begin
            pol_r        <= pol_nxt;
            man_strap_r  <= man_strap_nxt;
            aut_strap_r  <= aut_strap_nxt;
            strap_take_r <= strap_take_nxt;
            mode_r       <= mode_nxt;
            xo_src_r     <= xo_src_nxt;
            xo_auto_r    <= xo_auto_nxt;
            xo_state_r   <= xo_state_nxt;
            hb_dis_r     <= hb_dis_nxt;
            pll_lock_r   <= pll_lock_nxt;
            o_rdata      <= rdata_nxt;
            o_basic_ctrl_bits <= bc_nxt;
            o_basic_ctrl_mask <= bcm_nxt;
            o_adv_bits   <= adv_nxt;
            o_adv_valid  <= advv_nxt;
            o_power_down <= pd_nxt;
            o_crs_on_tx  <= crs_tx_nxt;
            o_repeater_mode <= rep_nxt;
            o_crossover_mode <= xo_nxt;
            o_heartbeat_test_en <= hb_en_nxt; // [RL10]
            o_rx_pll_force_reference_lock <= pll_out_nxt; // [RL11]
        end
    end
endmodule
`default_nettype wire

/* File: testbench/phy_mode_and_mdix_control_asserts.sv */
// Purpose: port checks for phy mode and crossover control
// Assumes: crossover code 11 is never written
// Notes: bound to the block at the foot
`default_nettype none
module phy_mode_and_mdix_control_asserts
    import phy_cfg_pkg::*;
(
    input wire logic        i_clk_sys,
    input wire logic        i_srst,
    input wire logic        i_phy_chip_rst,
    input wire logic [4:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic        o_power_down,
    input wire logic        o_repeater_mode,
    input wire logic [1:0]  o_crossover_mode,
    input wire logic        o_heartbeat_test_en,
    input wire logic        o_rx_pll_force_reference_lock
);
    wire logic w_ctl;
    wire logic w_mod;
    // chip-level reset beats a write in the same cycle
    assign w_ctl = i_wr && !i_phy_chip_rst && i_addr == IDX_SPECIAL_CTRL_IND;
    assign w_mod = i_wr && i_addr == IDX_SPECIAL_MODES;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    chk_hb_test: assert property (w_ctl |-> ##2
        o_heartbeat_test_en == !$past(i_wdata[11], 2)) else $error("hb");
    chk_pll_lock: assert property (w_ctl |-> ##2
        o_rx_pll_force_reference_lock == $past(i_wdata[10], 2))
        else $error("pll");
    chk_xo_reg: assert property (w_ctl && i_wdata[15] |-> ##2
        o_crossover_mode == $past(i_wdata[14:13], 2)) else $error("xo");
    chk_chip_clear: assert property (i_phy_chip_rst |-> ##2
        o_heartbeat_test_en && !o_rx_pll_force_reference_lock)
        else $error("clr");
    chk_pwr_down: assert property (w_mod |-> ##2
        o_power_down == ($past(i_wdata[7:5], 2) == 3'b110)) else $error("pd");
    chk_repeater_on: assert property (w_mod |-> ##2
        o_repeater_mode == ($past(i_wdata[7:5], 2) == 3'b101))
        else $error("rep");
    chk_ctl_resv: assert property ($past(i_rd) &&
        $past(i_addr) == IDX_SPECIAL_CTRL_IND |-> (o_rdata & 16'h13ef) == 0)
        else $error("ctrl reserved");
    chk_mode_resv: assert property ($past(i_rd) &&
        $past(i_addr) == IDX_SPECIAL_MODES |-> (o_rdata & 16'hff1f) == 0)
        else $error("mode reserved");
    cover property (w_ctl && i_wdata[15:13] == 3'b110);
    cover property (w_mod && i_wdata[7:5] == 3'b110);
    cover property (i_phy_chip_rst);
endmodule
bind phy_mode_and_mdix_control phy_mode_and_mdix_control_asserts chk_inst (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_phy_chip_rst(i_phy_chip_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_power_down(o_power_down),
    .o_repeater_mode(o_repeater_mode), .o_crossover_mode(o_crossover_mode),
    .o_heartbeat_test_en(o_heartbeat_test_en),
    .o_rx_pll_force_reference_lock(o_rx_pll_force_reference_lock));
`default_nettype wire

/* File: testbench/phy_host_model.sv */
// Purpose: management host model on the register port
// Assumes: one access in flight, strobes one cycle long
// Notes: read data taken in the cycle after the strobe
`default_nettype none
module phy_host_model
    import phy_cfg_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic [15:0] i_rdata,
    output logic [4:0]       o_addr = 5'h00,
    output logic [15:0]      o_wdata = 16'h0000,
    output logic             o_wr = 1'b0,
    output logic             o_rd = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic sane;
        sane = !(a == IDX_SPECIAL_CTRL_IND && d[14]);
        @(posedge i_clk_sys);
        o_addr <= a;
        o_wdata <= {d[15:14], d[13] & sane, d[12:0]};
        o_wr <= 1'b1;
        @(posedge i_clk_sys);
        o_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge i_clk_sys);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk_sys);
        o_rd <= 1'b0;
        #1;
        d = i_rdata;
    endtask
endmodule
`default_nettype wire

/* File: testbench/phy_mode_and_mdix_control_test.sv */
// Purpose: self-checking bench for phy mode and crossover control
// Assumes: straps change only while reset is held
// Notes: mode decode packed into one word for comparison
`default_nettype none
module phy_mode_and_mdix_control_test
    import phy_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] DEC [8] = '{16'h0f02, 16'h1f00, 16'h8f02,
        16'h9f00, 16'hcf4a, 16'hcf49, 16'h0004, 16'h46fa};
    localparam logic [15:0] CORNER [4] = '{16'h8000, 16'ha000, 16'hc000,
        16'he000};
    logic        clk_sys = 1'b0;
    logic        srst = 1'b1;
    logic        chip_rst = 1'b0;
    logic        soft_rst = 1'b0;
    logic        pol = 1'b0;
    logic [4:0]  straps = 5'h01;
    logic [31:0] lfsr_r = 32'hb14fa82e;
    logic [4:0]  addr;
    logic [15:0] wdata, rdata, got;
    logic        wr, rd, av, pd, crs, rep, hb, pll;
    logic [3:0]  bc, bm, adv;
    logic [1:0]  xo;
    wire logic [15:0] dec_seen;
    int unsigned error_cnt = 0;
    int unsigned checked = 0;
    assign dec_seen = {bc & bm, bm, av ? adv : 4'h0, av, pd, crs, rep};
    always #5 clk_sys = ~clk_sys;
    phy_mode_and_mdix_control phy_mode_and_mdix_control_inst (
        .i_clk_sys(clk_sys), .i_srst(srst), .i_phy_chip_rst(chip_rst),
        .i_phy_soft_rst(soft_rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .i_autoneg_strap(straps[4]),
        .i_speed_strap(straps[3]), .i_duplex_strap(straps[2]),
        .i_manual_xo_strap(straps[1]), .i_auto_xo_strap(straps[0]),
        .i_rx_polarity_reversed(pol), .o_rdata(rdata),
        .o_basic_ctrl_bits(bc), .o_basic_ctrl_mask(bm), .o_adv_bits(adv),
        .o_adv_valid(av), .o_power_down(pd), .o_crs_on_tx(crs),
        .o_repeater_mode(rep), .o_crossover_mode(xo),
        .o_heartbeat_test_en(hb), .o_rx_pll_force_reference_lock(pll));
    phy_host_model host (
        .i_clk_sys(clk_sys), .i_rdata(rdata), .o_addr(addr),
        .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic rnd(output logic [15:0] v);
        lfsr_r = lfsr_next(lfsr_r);
        v = lfsr_r[15:0];
    endtask
    // expected register image: host never sends code 11
    function automatic logic [15:0] ctl_expect(input logic [15:0] v);
        logic [15:0] e;
        e = v & 16'hec00;
        e[13] = e[13] & !e[14];
        return e;
    endfunction
    // crossover: register bits when bit 15 is set, else latched straps
    function automatic logic [1:0] xo_expect(input logic [15:0] c,
                                              input logic [1:0]  s);
        if (c[15])
            return c[14:13];
        return s[0] ? 2'b10 : {1'b0, s[1]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // straps change only while reset is held
    task automatic do_reset(input logic [2:0] s, input logic man,
                            input logic aut);
        @(posedge clk_sys);
        srst <= 1'b1;
        straps <= {s, man, aut};
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic mode_chk(input logic [2:0] m);
        repeat (2) @(posedge clk_sys);
        #1;
        check(dec_seen, DEC[m]);
        host.rd(IDX_SPECIAL_MODES, got);
        check(got, {8'h00, m, 5'h00});
    endtask
    // slack covers the polarity synchroniser
    task automatic ctl_chk(input logic [15:0] c);
        logic [1:0] xe;
        xe = xo_expect(c, straps[1:0]);
        repeat (4) @(posedge clk_sys);
        #1;
        check({14'h0, xo}, {14'h0, xe});
        check({14'h0, hb, pll}, {14'h0, !c[11], c[10]});
        host.rd(IDX_SPECIAL_CTRL_IND, got);
        check(got, c | {11'h0, pol, 4'h0});
    endtask
    initial begin
        #100us;
        error_cnt++;
        conclude();
    end
    initial begin
        logic [15:0] v;
        logic [15:0] c;
        for (int r = 0; r < 2; r++) begin
            rnd(v);
            do_reset({r[0], v[1:0]}, v[2], !r[0]);
            mode_chk(r[0] ? 3'h7 : {1'b0, v[1:0]});
            ctl_chk(16'h0000);
            for (int m = 0; m < 8; m++) begin
                rnd(v);
                host.wr(IDX_SPECIAL_MODES, {v[15:8], m[2:0], v[4:0]});
                mode_chk(m[2:0]);
            end
            for (int k = 0; k < 8; k++) begin
                rnd(v);
                if (k < 4)
                    v = CORNER[k] | (v & 16'h1fff);
                @(posedge clk_sys);
                pol <= v[9];
                host.wr(IDX_SPECIAL_CTRL_IND, v);
                c = ctl_expect(v);
                ctl_chk(c);
            end
            @(posedge clk_sys);
            soft_rst <= 1'b1;
            @(posedge clk_sys);
            soft_rst <= 1'b0;
            ctl_chk(c);
            @(posedge clk_sys);
            chip_rst <= 1'b1;
            @(posedge clk_sys);
            chip_rst <= 1'b0;
            ctl_chk(16'h0000);
            mode_chk(3'h7);
            host.rd(5'h05, got);
            check(got, 16'h0000);
            $display("round %0d done", r);
        end
        conclude();
    end
endmodule
`default_nettype wire
